// ===== shared/status_pkg.sv
// constants, register layout and types for the serial port status block
// Operation
// R1: receive buffer occupancy count, 5 bits, read-only in bits 28..24, enhanced mode only
// R2: transmit buffer occupancy count, 5 bits, read-only in bits 20..16, enhanced mode only
// R3: frame error flag bit 12 set by hardware, software clears it, framed mode
// R4: bit 11 high while the port processes any transaction, low when idle
// R5: bit 8 set on transmit underrun in framed mode, cleared only by disable
// R6: bit 7 high while the shift register holds no data, enhanced mode only
// R7: bit 6 set when a received word is discarded unread; cleared only by writing zero
// R8: bit 5 high when receive FIFO read and write pointers are equal; the code sets it in enhanced mode only and reads zero otherwise
// R9: unimplemented bits 31..29, 23..21, 15..13, 10..9 and 4 read as zero
// R10: bits 3, 1, 0 show tx empty, tx full, rx full; tx empty resets to one
// R11: software writes to read-only positions are ignored; only bits 6 and 12 writable
package status_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0]  status_offset   = 4'h0;
  localparam logic [3:0]  int_stat_offset = 4'h4;
  localparam logic [3:0]  int_mask_offset = 4'h8;
  localparam logic [3:0]  control_offset  = 4'hC;
  // ==========================================================
  // field positions of the status word
  localparam int rx_count_lsb   = 24;
  localparam int tx_count_lsb   = 16;
  localparam int frame_err_bit  = 12;
  localparam int active_bit     = 11;
  localparam int underrun_bit   = 8;
  localparam int shifter_bit    = 7;
  localparam int overflow_bit   = 6;
  localparam int rx_empty_bit   = 5;
  localparam int tx_empty_bit   = 3;
  localparam int tx_full_bit    = 1;
  localparam int rx_full_bit    = 0;
  localparam int count_width    = 5;
  // ==========================================================
  // interrupt event bits
  localparam int ev_frame_err   = 0;
  localparam int ev_overflow    = 1;
  localparam int ev_underrun    = 2;
  localparam int event_count    = 3;
  // control register bits
  localparam int ctl_enable     = 0;
  localparam int ctl_enhanced   = 1;
  localparam int ctl_framed     = 2;
  localparam logic [2:0] control_reset = 3'h0;
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // signals from the shift engine and FIFOs
  typedef struct packed {
    logic [4:0] rx_count;
    logic [4:0] tx_count;
    logic       busy;
    logic       shifter_empty;
    logic [4:0] rd_ptr;
    logic [4:0] wr_ptr;
    logic       tx_empty;
    logic       tx_full;
    logic       rx_full;
    logic       frame_err_ev;
    logic       underrun_ev;
    logic       rx_done_ev;
  } engine_s;
endpackage : status_pkg

// ===== verilog/status_axi_slave.sv
// AXI4-Lite slave front end: handshakes and one-cycle access strobes
`timescale 1ns/1ps
module status_axi_slave (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_go,
  output logic [3:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic             rd_go,
  output logic [3:0]       rd_addr,
  input  wire logic [31:0] rd_value,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);
  import status_pkg::*;
  logic aw_held;
  logic w_held;
  wire  aw_take = s_awvalid & s_awready;
  wire  w_take  = s_wvalid & s_wready;
  wire  both    = (aw_held | aw_take) & (w_held | w_take);
  wire  next_wr = both & ~s_bvalid & ~wr_go;

  // ==========================================================
  // write channel: address and data in either order, then one response
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_awready <= 1'b1; s_wready <= 1'b1; aw_held <= 1'b0; w_held <= 1'b0;
      s_bvalid <= 1'b0; s_bresp <= resp_okay; wr_go <= 1'b0;
      wr_addr <= 4'h0; wr_data <= 32'h0; wr_strb <= 4'h0;
    end else if (clk_en) begin
      wr_go <= next_wr;
      if (aw_take) begin
        wr_addr <= s_awaddr; aw_held <= 1'b1; s_awready <= 1'b0;
      end
      if (w_take) begin
        wr_data <= s_wdata; wr_strb <= s_wstrb; w_held <= 1'b1; s_wready <= 1'b0;
      end
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_hit ? resp_okay : resp_slverr;
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0; s_awready <= 1'b1; s_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read channel: address taken, data one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_arready <= 1'b1; s_rvalid <= 1'b0; s_rdata <= 32'h0; s_rresp <= resp_okay;
      rd_go <= 1'b0; rd_addr <= 4'h0;
    end else if (clk_en) begin
      rd_go <= s_arvalid & s_arready;
      if (s_arvalid && s_arready) begin
        rd_addr <= s_araddr; s_arready <= 1'b0;
      end
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_hit ? rd_value : 32'h0;
        s_rresp  <= rd_hit ? resp_okay : resp_slverr;
      end
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0; s_arready <= 1'b1;
      end
    end
  end
endmodule : status_axi_slave

// ===== verilog/serial_port_status_flags.sv
// serial port status register with sticky flags, interrupts and AXI4-Lite access
`timescale 1ns/1ps
module serial_port_status_flags (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire status_pkg::engine_s engine,
  input  wire logic [3:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [3:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  output logic                   module_enable,
  output logic                   enhanced_buffer_select,
  output logic                   framed_operation_enable,
  output logic                   irq
);
  import status_pkg::*;

  // ==========================================================
  // state
  logic                   frame_error_flag;
  logic                   rx_overflow_flag;
  logic                   tx_underrun_flag;
  logic                   tx_buffer_empty_flag;
  logic                   tx_buffer_full_flag;
  logic                   rx_buffer_full_flag;
  logic                   port_active_flag;
  logic                   shifter_empty_flag;
  logic                   rx_fifo_empty_flag;
  logic [count_width-1:0] rx_element_count;
  logic [count_width-1:0] tx_element_count;
  logic [event_count-1:0] int_status;
  logic [event_count-1:0] int_mask;
  logic                   wr_go;
  logic [3:0]             wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic                   rd_go;
  logic [3:0]             rd_addr;

  // ==========================================================
  // address decode, shared by read and write sides
  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == status_offset) || (a == int_stat_offset) ||
             (a == int_mask_offset) || (a == control_offset);
  endfunction : mapped

  wire wr_status  = wr_go & (wr_addr == status_offset) & wr_strb[0] ;
  wire wr_status1 = wr_go & (wr_addr == status_offset) & wr_strb[1];
  wire wr_istat   = wr_go & (wr_addr == int_stat_offset) & wr_strb[0];
  wire wr_imask   = wr_go & (wr_addr == int_mask_offset) & wr_strb[0];
  wire wr_ctl     = wr_go & (wr_addr == control_offset) & wr_strb[0];

  // discard happens when a word completes while the previous one is unread
  // the full flag is the registered copy, so it lags the engine by one cycle
  wire overflow_ev = engine.rx_done_ev & rx_buffer_full_flag;
  wire frame_ev    = engine.frame_err_ev & framed_operation_enable;
  wire underrun_ev = engine.underrun_ev & framed_operation_enable;
  wire [event_count-1:0] events = {underrun_ev, overflow_ev, frame_ev};

  // software may only clear the two clearable flags; a set in the same cycle wins
  wire clear_frame = wr_status1 & ~wr_data[frame_err_bit]; // R3
  wire clear_ovf   = wr_status & ~wr_data[overflow_bit];   // R7
  wire next_frame  = frame_ev | (frame_error_flag & ~clear_frame); // R3
  wire next_ovf    = overflow_ev | (rx_overflow_flag & ~clear_ovf); // R7
  // underrun survives until the module is switched off
  wire next_tur    = module_enable & (underrun_ev | tx_underrun_flag); // R5

  // ==========================================================
  // status word assembly; unimplemented positions are constant zero
  wire [31:0] status_word = {
    3'h0, rx_element_count,                                  // R1 R9
    3'h0, tx_element_count,                                  // R2 R9
    3'h0, frame_error_flag, port_active_flag, 2'h0,          // R3 R4 R9
    tx_underrun_flag,                                        // R5
    shifter_empty_flag, rx_overflow_flag, rx_fifo_empty_flag,// R6 R7 R8
    1'b0, tx_buffer_empty_flag, 1'b0,                        // R9 R10
    tx_buffer_full_flag, rx_buffer_full_flag};               // R10

  // read mux; unmapped addresses fall through here but the bus returns zero for them
  wire [31:0] rd_value =
    (rd_addr == status_offset)   ? status_word :
    (rd_addr == int_stat_offset) ? {29'h0, int_status} :
    (rd_addr == int_mask_offset) ? {29'h0, int_mask} :
    {29'h0, framed_operation_enable, enhanced_buffer_select, module_enable};

  // ==========================================================
  // sticky flags: frame error and overflow cleared by software, underrun by disable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      frame_error_flag <= 1'b0;
      rx_overflow_flag <= 1'b0;
      tx_underrun_flag <= 1'b0;
    end else if (clk_en) begin
      frame_error_flag <= next_frame;
      rx_overflow_flag <= next_ovf;
      tx_underrun_flag <= next_tur;
    end
  end

  // ==========================================================
  // live status copied from the engine; writes never reach these
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_buffer_empty_flag <= 1'b1; // R10
      tx_buffer_full_flag  <= 1'b0;
      rx_buffer_full_flag  <= 1'b0;
      port_active_flag     <= 1'b0;
      shifter_empty_flag   <= 1'b0;
      rx_fifo_empty_flag   <= 1'b0;
      rx_element_count     <= '0;
      tx_element_count     <= '0;
    end else if (clk_en) begin
      tx_buffer_empty_flag <= engine.tx_empty;                         // R10 R11
      tx_buffer_full_flag  <= engine.tx_full;                          // R10
      rx_buffer_full_flag  <= engine.rx_full;                          // R10
      port_active_flag     <= engine.busy;                             // R4
      // counts and fifo flags only mean something in enhanced mode
      shifter_empty_flag   <= enhanced_buffer_select & engine.shifter_empty;       // R6
      rx_fifo_empty_flag   <= enhanced_buffer_select & (engine.rd_ptr == engine.wr_ptr); // R8
      rx_element_count     <= enhanced_buffer_select ? engine.rx_count : '0;       // R1
      tx_element_count     <= enhanced_buffer_select ? engine.tx_count : '0;       // R2
    end
  end

  // ==========================================================
  // interrupt status (write one to clear, set wins), mask and control
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      int_status              <= '0;
      int_mask                <= '0;
      module_enable           <= control_reset[ctl_enable];
      enhanced_buffer_select  <= control_reset[ctl_enhanced];
      framed_operation_enable <= control_reset[ctl_framed];
      irq                     <= 1'b0;
    end else if (clk_en) begin
      int_status <= events | (int_status & ~(wr_istat ? wr_data[event_count-1:0] : '0));
      if (wr_imask) int_mask <= wr_data[event_count-1:0];
      if (wr_ctl) begin
        module_enable           <= wr_data[ctl_enable];
        enhanced_buffer_select  <= wr_data[ctl_enhanced];
        framed_operation_enable <= wr_data[ctl_framed];
      end
      irq <= |(int_status & int_mask);
    end
  end

  // ==========================================================
  // bus front end owns the handshakes and hands over one-cycle strobes
  status_axi_slave u_bus (
    .clock     (clock),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_go     (wr_go),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .rd_go     (rd_go),
    .rd_addr   (rd_addr),
    .rd_value  (rd_value),
    .rd_hit    (mapped(rd_addr)),
    .wr_hit    (mapped(wr_addr))
  );

  // ==========================================================
  // checks: named steps of the flag behaviour
  sequence zero_write_s;
    clk_en && wr_status && !wr_data[overflow_bit] && !overflow_ev;
  endsequence
  sequence frame_zero_s;
    clk_en && wr_status1 && !wr_data[frame_err_bit] && !frame_ev;
  endsequence
  sequence enable_drop_s;
    clk_en && !module_enable;
  endsequence
  sequence enhanced_on_s;
    clk_en && enhanced_buffer_select;
  endsequence

  // overflow: set by a discarded word, kept until a zero is written
  ovf_set_a : assert property (@(posedge clock) disable iff (!arst_n) // R7
    clk_en && overflow_ev |=> rx_overflow_flag)
    else $error("overflow not flagged");
  ovf_clear_a : assert property (@(posedge clock) disable iff (!arst_n) // R7
    zero_write_s |=> !rx_overflow_flag)
    else $error("overflow not cleared");
  ovf_hold_a : assert property (@(posedge clock) disable iff (!arst_n) // R7
    clk_en && rx_overflow_flag && !wr_status |=> rx_overflow_flag)
    else $error("overflow lost");

  // frame error: framed mode only, cleared by a written zero
  frame_set_a : assert property (@(posedge clock) disable iff (!arst_n) // R3
    clk_en && frame_ev |=> frame_error_flag)
    else $error("frame error not flagged");
  frame_clear_a : assert property (@(posedge clock) disable iff (!arst_n) // R3
    frame_zero_s |=> !frame_error_flag)
    else $error("frame error not cleared");
  frame_hold_a : assert property (@(posedge clock) disable iff (!arst_n) // R3
    clk_en && frame_error_flag && !wr_status1 |=> frame_error_flag)
    else $error("frame error lost");
  frame_gate_a : assert property (@(posedge clock) disable iff (!arst_n) // R3
    clk_en && !framed_operation_enable && !frame_error_flag |=> !frame_error_flag)
    else $error("frame error outside framed mode");

  // underrun: framed mode only, and only a disable clears it
  tur_set_a : assert property (@(posedge clock) disable iff (!arst_n) // R5
    clk_en && underrun_ev && module_enable |=> tx_underrun_flag)
    else $error("underrun not flagged");
  tur_clear_a : assert property (@(posedge clock) disable iff (!arst_n) // R5
    enable_drop_s |=> !tx_underrun_flag)
    else $error("underrun not cleared by disable");
  tur_hold_a : assert property (@(posedge clock) disable iff (!arst_n) // R5
    clk_en && tx_underrun_flag && module_enable |=> tx_underrun_flag)
    else $error("underrun lost");
  tur_gate_a : assert property (@(posedge clock) disable iff (!arst_n) // R5
    clk_en && !framed_operation_enable && !tx_underrun_flag |=> !tx_underrun_flag)
    else $error("underrun outside framed mode");

  // live levels trail the engine by one cycle
  busy_follow_a : assert property (@(posedge clock) disable iff (!arst_n) // R4
    clk_en |=> port_active_flag == $past(engine.busy))
    else $error("busy flag wrong");
  live_flags_a : assert property (@(posedge clock) disable iff (!arst_n) // R10
    clk_en |=> tx_buffer_empty_flag == $past(engine.tx_empty) && tx_buffer_full_flag == $past(engine.tx_full)
    && rx_buffer_full_flag == $past(engine.rx_full))
    else $error("buffer flags wrong");

  // enhanced-mode fields follow the engine and read zero otherwise
  count_follow_a : assert property (@(posedge clock) disable iff (!arst_n) // R1 R2
    enhanced_on_s |=> rx_element_count == $past(engine.rx_count)
    && tx_element_count == $past(engine.tx_count))
    else $error("element count wrong");
  count_gate_a : assert property (@(posedge clock) disable iff (!arst_n) // R1 R2
    clk_en && !enhanced_buffer_select |=> rx_element_count == '0 && tx_element_count == '0)
    else $error("count outside enhanced mode");
  shifter_follow_a : assert property (@(posedge clock) disable iff (!arst_n) // R6
    enhanced_on_s |=> shifter_empty_flag == $past(engine.shifter_empty))
    else $error("shifter empty wrong");
  mode_gate_a : assert property (@(posedge clock) disable iff (!arst_n) // R6 R8
    clk_en && !enhanced_buffer_select |=> !shifter_empty_flag && !rx_fifo_empty_flag)
    else $error("fifo flags outside enhanced mode");
  fifo_empty_a : assert property (@(posedge clock) disable iff (!arst_n) // R8
    clk_en && enhanced_buffer_select && engine.rd_ptr != engine.wr_ptr |=> !rx_fifo_empty_flag)
    else $error("fifo empty wrong");
  fifo_equal_a : assert property (@(posedge clock) disable iff (!arst_n) // R8
    clk_en && enhanced_buffer_select && engine.rd_ptr == engine.wr_ptr |=> rx_fifo_empty_flag)
    else $error("fifo empty missed");

  // bus answers and reserved positions as software sees them
  reserved_zero_a : assert property (@(posedge clock) disable iff (!arst_n) // R9
    s_rvalid && rd_addr == status_offset |-> (s_rdata & 32'hE0E0_E610) == 32'h0)
    else $error("reserved bit set");
  write_answer_a : assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && wr_go |=> s_bvalid)
    else $error("write not answered");
  read_answer_a : assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && rd_go |=> s_rvalid)
    else $error("read not answered");

  // interrupt status, irq level and the clock-enable freeze
  event_set_a : assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && events != '0 |=> (int_status & $past(events)) == $past(events))
    else $error("event not latched");
  irq_raise_a : assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && (int_status & int_mask) != '0 |=> irq)
    else $error("irq not raised");
  irq_mask_a : assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && int_mask == '0 |=> !irq)
    else $error("irq while masked");
  freeze_hold_a : assert property (@(posedge clock) disable iff (!arst_n)
    !clk_en |=> $stable(status_word) && $stable(int_status) && $stable(irq))
    else $error("state moved while frozen");
endmodule : serial_port_status_flags

// ===== tb/engine_model.sv
// behavioural shift engine and fifo model feeding the status block
`timescale 1ns/1ps
module engine_model (
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire status_pkg::engine_s levels,
  input  wire logic [2:0]          fire,
  output status_pkg::engine_s      engine
);
  import status_pkg::*;
  // ==========================================================
  // engine outputs: levels follow the bench one cycle later, events are one-cycle pulses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      engine          <= '0;
      engine.tx_empty <= 1'b1; // idle engine has nothing queued to send
    end else begin
      engine              <= levels;
      engine.frame_err_ev <= fire[0];
      engine.underrun_ev  <= fire[1];
      engine.rx_done_ev   <= fire[2];
    end
  end
endmodule : engine_model

// ===== tb/tb_serial_port_status_flags.sv
// self-checking bench for the serial port status block
`timescale 1ns/1ps
module tb_serial_port_status_flags;
  import status_pkg::*;
  logic clock, arst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, module_enable, enhanced_buffer_select;
  logic framed_operation_enable, irq, clk_en;
  logic [3:0]  s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [2:0]  fire;
  engine_s     lv, engine;
  int          miscompares, n_tests;
  // ==========================================================
  // clock, instances
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  engine_model far (.clock(clock), .arst_n(arst_n), .levels(lv), .fire(fire), .engine(engine));
  serial_port_status_flags DUT (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .engine(engine),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .module_enable(module_enable), .enhanced_buffer_select(enhanced_buffer_select),
    .framed_operation_enable(framed_operation_enable), .irq(irq));
  // ==========================================================
  // helpers: compare, bus cycles, event pulses
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // the master waits for each answer; only the watchdog cuts a hang
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (!aw_done && s_awready) begin aw_done = 1'b1; s_awvalid <= 1'b0; end
      if (!w_done && s_wready) begin w_done = 1'b1; s_wvalid <= 1'b0; end
      if (s_bvalid) begin rsp = s_bresp; s_bready <= 1'b0; break; end
    end
    @(posedge clock); // bready rests low for one edge before the next write raises it
  endtask : wr
  task automatic rdreg(input logic [3:0] a);
    logic ar_done;
    ar_done = 1'b0;
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (!ar_done && s_arready) begin ar_done = 1'b1; s_arvalid <= 1'b0; end
      if (s_rvalid) begin rd = s_rdata; rsp = s_rresp; s_rready <= 1'b0; break; end
    end
    @(posedge clock); // rready rests low for one edge before the next read raises it
  endtask : rdreg
  task automatic pulse(input int which);
    fire[which] <= 1'b1;
    @(posedge clock);
    fire <= 3'h0;
    repeat (3) @(posedge clock);
  endtask : pulse
  task automatic conclude();
    $display("tests %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdreg(status_offset); chk(rd, 32'h0000_0008, "status after reset");
    rdreg(control_offset); chk(rd, 32'h0, "control after reset");
    chk({30'h0, rsp}, {30'h0, resp_okay}, "mapped read response");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("reset values done");
  endtask : t_reset
  task automatic t_fields();
    lv <= '{rx_count: 5'h1F, tx_count: 5'h11, busy: 1'b1, shifter_empty: 1'b1, rd_ptr: 5'h3,
            wr_ptr: 5'h4, tx_full: 1'b1, rx_full: 1'b1, default: 1'b0};
    wr(control_offset, 32'h7);
    chk({30'h0, rsp}, {30'h0, resp_okay}, "mapped write response");
    chk({29'h0, framed_operation_enable, enhanced_buffer_select, module_enable}, 32'h7, "controls");
    rdreg(status_offset); chk(rd, 32'h1F11_0883, "fields, pointers differ");
    lv.wr_ptr <= 5'h3;
    repeat (3) @(posedge clock);
    rdreg(status_offset); chk(rd, 32'h1F11_08A3, "fields, pointers equal");
    wr(control_offset, 32'h5);
    rdreg(status_offset); chk(rd, 32'h0000_0803, "fields, enhanced off");
    $display("status fields done");
  endtask : t_fields
  task automatic t_overflow();
    lv <= '{tx_empty: 1'b1, rx_full: 1'b1, default: 1'b0};
    wr(control_offset, 32'h1);
    wr(int_stat_offset, 32'h7);
    wr(int_mask_offset, 32'h2);
    pulse(2);
    rdreg(status_offset); chk(rd, 32'h0000_0049, "overflow set");
    chk({31'h0, irq}, 32'h1, "irq on overflow");
    wr(status_offset, 32'hFFFF_FFFF);
    rdreg(status_offset); chk(rd, 32'h0000_0049, "write ones ignored");
    wr(int_mask_offset, 32'h0);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(int_mask_offset, 32'h2);
    wr(int_stat_offset, 32'h2);
    rdreg(int_stat_offset); chk(rd, 32'h0, "event bit cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(status_offset, 32'h0);
    rdreg(status_offset); chk(rd, 32'h0000_0009, "overflow cleared by zero");
    $display("overflow and interrupt done");
  endtask : t_overflow
  task automatic t_framed();
    wr(control_offset, 32'h5);
    pulse(0);
    rdreg(status_offset); chk(rd, 32'h0000_1009, "frame error set");
    wr(status_offset, 32'h0);
    rdreg(status_offset); chk(rd, 32'h0000_0009, "frame error cleared");
    pulse(1);
    rdreg(status_offset); chk(rd, 32'h0000_0109, "underrun set");
    wr(status_offset, 32'h0);
    rdreg(status_offset); chk(rd, 32'h0000_0109, "underrun survives write");
    wr(control_offset, 32'h4);
    wr(control_offset, 32'h5);
    rdreg(status_offset); chk(rd, 32'h0000_0009, "underrun cleared by disable");
    $display("framed flags done");
  endtask : t_framed
  // an event that arrives while the clock enable is low must leave no trace
  task automatic t_freeze();
    clk_en <= 1'b0;
    pulse(0);
    clk_en <= 1'b1;
    rdreg(status_offset); chk(rd, 32'h0000_0009, "event while frozen");
    $display("clock enable done");
  endtask : t_freeze
  task automatic t_unmapped();
    wr(4'h2, 32'hFFFF_FFFF); chk({30'h0, rsp}, {30'h0, resp_slverr}, "unmapped write");
    rdreg(4'h2); chk({30'h0, rsp}, {30'h0, resp_slverr}, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    rdreg(status_offset); chk(rd, 32'h0000_0009, "no side effect");
    $display("unmapped access done");
  endtask : t_unmapped
  // ==========================================================
  // main sequence and watchdog
  initial begin
    miscompares = 0; n_tests = 0; arst_n = 1'b0; fire = 3'h0; lv = '0; lv.tx_empty = 1'b1;
    clk_en = 1'b1;
    s_awaddr = 4'h0; s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'hF; s_wvalid = 1'b0;
    s_bready = 1'b0; s_araddr = 4'h0; s_arvalid = 1'b0; s_rready = 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_fields();
    t_overflow();
    t_framed();
    t_freeze();
    t_unmapped();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    conclude();
  end
endmodule : tb_serial_port_status_flags
